// ---- hdl/timing_relay_pkg.sv ----
// Shared types and constants for the multi-mode timing relay
package timing_relay_pkg;
	localparam int SP_W = 16;
	localparam int T_W = 24;
	// Setpoint conversion factors and limits
	localparam logic [T_W-1:0] SEC_PER_MIN = 24'h00003c;
	localparam logic [T_W-1:0] TEN_MS_STEP = 24'h00000a;
	localparam logic [T_W-1:0] ROUND_STEP = 24'h000005;
	localparam logic [SP_W-1:0] MAX_S_UNITS = 16'h270f;
	localparam logic [SP_W-1:0] MAX_MS_SEC = 16'h176f;
	localparam logic [SP_W-1:0] MAX_HM_MIN = 16'h176f;
	// Tick rates at 250 MHz: 10 ms, 1 s, 1 min
	localparam int CLK_HZ = 250000000;
	localparam int TICK_10MS_NS = 10000000;
	localparam int CLK_NS = 4;
	localparam int TICK_CYC_DEF = TICK_10MS_NS / CLK_NS;
	localparam logic [T_W-1:0] ONE = 24'h000001;
	// Last 10 ms tick of a 1 s step and of a 1 min step
	localparam logic [12:0] SUB_LAST_SEC = 13'h0063;
	localparam logic [12:0] SUB_LAST_MIN = 13'h176f;
	// Any non-zero seed keeps the random source running
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	typedef enum logic [1:0] {
		BASE_S,
		BASE_MS,
		BASE_HM
	} time_base_t;

	typedef enum logic [2:0] {
		MODE_ON_DELAY,
		MODE_OFF_DELAY,
		MODE_ON_OFF,
		MODE_PULSE,
		MODE_FLASH
	} relay_mode_t;

	typedef struct packed {
		logic trigger_coil;
		logic hold_coil;
		logic clear_coil;
	} coils_t;

	typedef struct packed {
		relay_mode_t mode;
		time_base_t base;
		logic random_en;
		logic [SP_W-1:0] time_setpoint_one;
		logic [SP_W-1:0] time_setpoint_two;
	} relay_cfg_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} split_t;
endpackage

// ---- hdl/multi_mode_timing_relay.sv ----
// Timing relay block: five modes, random variants, setpoint conversion
`timescale 1ns/1ps
`default_nettype none
// Function
// - M:S base: setpoint is seconds; minutes = value/60, seconds = remainder.
// - H:M base: setpoint is minutes; hours = value/60, minutes = remainder.
// - On-delay: trigger falling early clears elapsed; next trigger restarts.
// - On-delay: stop freezes running delay; no effect after expiry.
// - On-delay: reset opens contact, clears count; a trigger still on restarts timing.
// - Off-delay: contact follows trigger; delay counts after trigger falls.
// - Off-delay: retrigger during delay clears elapsed; full delay reruns.
// - Off-delay: reset clears contact and timer, then normal operation.
// - Combined: setpoint one on-delay, two off-delay; stop suspends either.
// - Combined: trigger falling before on-delay never closes contact.
// - Combined: reset opens contact, zeros elapsed; a trigger still on restarts timing.
// - Combined: sp1>=sp2 or elapsed<sp1: retrigger holds elapsed.
// - Combined: sp1<sp2 and elapsed>=sp1: retrigger zeros elapsed.
// - Pulse: contact closes for setpoint one, stretching or cutting trigger.
// - Pulse: stop suspends timing; reset ends pulse despite active trigger.
// - Flash: toggles while triggered; mark sp1, space sp2.
// - Random variants of on-delay, off-delay and combined switch at a random time within the setpoint; pulse and flash ignore random_en.
// - Flash sequence starts with a mark phase.
// - Oversized setpoint is replaced by the time base maximum.
// - Seconds base: setpoint in 10 ms units, last digit rounded to 0 or 5.
module multi_mode_timing_relay #(
	parameter int TICK_CYC = timing_relay_pkg::TICK_CYC_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire timing_relay_pkg::coils_t coils,
	input wire timing_relay_pkg::relay_cfg_t cfg,
	output logic contact,
	output logic [timing_relay_pkg::T_W-1:0] elapsed,
	output timing_relay_pkg::split_t sp1_split,
	output timing_relay_pkg::split_t sp2_split
);
	import timing_relay_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ON_RUN,
		ST_ACTIVE,
		ST_OFF_RUN,
		ST_MARK,
		ST_SPACE,
		ST_DONE
	} state_t;

	typedef struct packed {
		state_t st;
		logic contact;
		logic [T_W-1:0] elapsed;
		logic [T_W-1:0] target;
		logic [31:0] div;
		logic [12:0] sub;
		logic [15:0] lfsr;
		split_t s1;
		split_t s2;
	} regs_t;

	regs_t q, d;
	logic tick;
	logic [T_W-1:0] sp1_t, sp2_t;
	logic trig, hold, clr;

	// ==========================================================
	// Setpoint scaling
	function automatic logic [T_W-1:0] scale(input logic [SP_W-1:0] v,
			input time_base_t b);
		logic [T_W-1:0] r;
		r = '0;
		unique case (b)
			BASE_S: begin
				r = {8'h00, (v > MAX_S_UNITS) ? MAX_S_UNITS : v};
				// Counts are 10 ms units; round up to a multiple of five
				r = ((r + ROUND_STEP - ONE) / ROUND_STEP) * ROUND_STEP;
			end
			BASE_MS: r = {8'h00, (v > MAX_MS_SEC) ? MAX_MS_SEC : v};
			BASE_HM: r = {8'h00, (v > MAX_HM_MIN) ? MAX_HM_MIN : v};
			// Unused base code: no delay at all
			default: r = '0;
		endcase
		return r;
	endfunction

	function automatic split_t split(input logic [SP_W-1:0] v);
		split_t s;
		logic [T_W-1:0] w;
		// Clamp first so hours or minutes never exceed 99
		w = {8'h00, (v > MAX_MS_SEC) ? MAX_MS_SEC : v};
		s.hi = 8'(w / SEC_PER_MIN);
		s.lo = 8'(w % SEC_PER_MIN);
		return s;
	endfunction

	function automatic logic [T_W-1:0] pick(input logic [T_W-1:0] sp,
			input logic [15:0] rnd, input logic en);
		logic [T_W-1:0] r;
		r = sp;
		if (en && sp != '0) begin
			r = ({8'h00, rnd} % sp) + ONE;
		end
		return r;
	endfunction

	always_comb begin
		sp1_t = scale(cfg.time_setpoint_one, cfg.base);
		sp2_t = scale(cfg.time_setpoint_two, cfg.base);
		trig = coils.trigger_coil;
		hold = coils.hold_coil && !coils.clear_coil;
		clr = coils.clear_coil;
	end

	// ==========================================================
	// Main sequencer
	always_comb begin
		d = q;
		d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
		d.s1 = split(cfg.time_setpoint_one);
		d.s2 = split(cfg.time_setpoint_two);

		// ==========================================================
		// Resolution ticks
		// The divider makes a 10 ms strobe; sub counts those strobes
		// into 1 s or 1 min steps for the coarser bases.
		// The divider runs freely, so the first step of a delay may
		// be short by up to one resolution step; the contact can
		// therefore switch up to one step early.
		tick = 1'b0;
		if (q.div == 32'(TICK_CYC - 1)) begin
			d.div = '0;
			d.sub = q.sub + 13'h0001;
			if (cfg.base == BASE_S) begin
				tick = 1'b1;
				d.sub = '0;
			end else if ((cfg.base == BASE_MS && q.sub >= SUB_LAST_SEC) ||
					(cfg.base == BASE_HM && q.sub >= SUB_LAST_MIN)) begin
				tick = 1'b1;
				d.sub = '0;
			end
		end else begin
			d.div = q.div + 32'd1;
		end

		// ==========================================================
		// Mode sequencing
		// Clear wins over everything; hold only gates the tick, so
		// expiry is still seen in the cycle the count reaches target.
		if (clr) begin
			d.st = ST_IDLE;
			d.contact = 1'b0;
			d.elapsed = '0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
					d.elapsed = '0;
					d.contact = 1'b0;
					if (trig) begin
						unique case (cfg.mode)
							MODE_ON_DELAY, MODE_ON_OFF: begin
								d.st = ST_ON_RUN;
								d.target = pick(sp1_t, q.lfsr, cfg.random_en);
							end
							MODE_OFF_DELAY: begin
								d.st = ST_ACTIVE;
								d.contact = 1'b1;
							end
							MODE_PULSE: begin
								d.st = ST_MARK;
								d.contact = 1'b1;
								d.target = sp1_t;
							end
							MODE_FLASH: begin
								d.st = ST_MARK;
								d.contact = 1'b1;
								d.target = sp1_t;
							end
							default: d.st = ST_IDLE;
						endcase
					end
				end
				ST_ON_RUN: begin
					if (!trig) begin
						d.st = ST_IDLE;
						d.elapsed = '0;
					end else if (q.elapsed >= q.target) begin
						d.st = ST_ACTIVE;
						d.contact = 1'b1;
						d.elapsed = '0;
					end else if (!hold && tick) begin
						d.elapsed = q.elapsed + ONE;
					end
				end
				ST_ACTIVE: begin
					if (cfg.mode == MODE_ON_DELAY) begin
						d.contact = trig;
						if (!trig) begin
							d.st = ST_IDLE;
						end
					end else if (!trig) begin
						d.st = ST_OFF_RUN;
						d.elapsed = '0;
						d.target = pick(cfg.mode == MODE_ON_OFF ? sp2_t : sp1_t,
							q.lfsr, cfg.random_en);
					end
				end
				ST_OFF_RUN: begin
					if (trig) begin
						if (cfg.mode == MODE_OFF_DELAY) begin
							d.st = ST_ACTIVE;
							d.elapsed = '0;
						end else if (sp1_t < sp2_t && q.elapsed >= sp1_t) begin
							d.elapsed = '0;
						end
						// Otherwise elapsed is held
					end else if (q.elapsed >= q.target) begin
						d.st = ST_IDLE;
						d.contact = 1'b0;
						d.elapsed = '0;
					end else if (!hold && tick) begin
						d.elapsed = q.elapsed + ONE;
					end
				end
				ST_MARK, ST_SPACE: begin
					if (cfg.mode == MODE_FLASH && !trig) begin
						d.st = ST_IDLE;
						d.contact = 1'b0;
						d.elapsed = '0;
					end else if (q.elapsed >= q.target) begin
						d.elapsed = '0;
						if (cfg.mode == MODE_PULSE) begin
							d.st = ST_DONE;
							d.contact = 1'b0;
						end else begin
							d.st = (q.st == ST_MARK) ? ST_SPACE : ST_MARK;
							d.contact = (q.st == ST_SPACE);
							d.target = (q.st == ST_MARK) ? sp2_t : sp1_t;
						end
					end else if (!hold && tick) begin
						d.elapsed = q.elapsed + ONE;
					end
				end
				ST_DONE: begin
					d.contact = 1'b0;
					if (!trig) begin
						d.st = ST_IDLE;
						d.elapsed = '0;
					end
				end
				default: d.st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.lfsr <= LFSR_SEED;
		end else begin
			q <= d;
		end
	end

	assign contact = q.contact;
	assign elapsed = q.elapsed;
	assign sp1_split = q.s1;
	assign sp2_split = q.s2;
endmodule // multi_mode_timing_relay
`default_nettype wire

// ---- sim/multi_mode_timing_relay_monitor.sv ----
// Port checker for the timing relay
`timescale 1ns/1ps
`default_nettype none
module relay_port_checker #(
	parameter int TICK_CYC = 4
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire timing_relay_pkg::coils_t coils,
	input wire timing_relay_pkg::relay_cfg_t cfg,
	input wire logic contact,
	input wire logic [timing_relay_pkg::T_W-1:0] elapsed,
	input wire timing_relay_pkg::split_t sp1_split,
	input wire timing_relay_pkg::split_t sp2_split
);
	import timing_relay_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire logic trig = coils.trigger_coil;
	wire logic clr = coils.clear_coil;
	wire logic free = !coils.hold_coil && !clr;
	sequence pulse_start;
		cfg.mode == MODE_PULSE && $rose(contact) && !clr;
	endsequence
	chk_clear_open:
		assert property (clr |=> !contact) else $error("clear kept contact");
	chk_clear_zero:
		assert property (clr |=> elapsed == '0) else $error("clear kept time");
	chk_hold_freeze:
		assert property (cfg.mode == MODE_ON_DELAY && coils.hold_coil && !clr
			&& trig && !contact |=> $stable(elapsed) || contact)
		else $error("hold let time move");
	chk_ondly_open:
		assert property (cfg.mode == MODE_ON_DELAY && !trig && free |=> !contact)
		else $error("on-delay closed without trigger");
	chk_offdly_follow:
		assert property (cfg.mode == MODE_OFF_DELAY && trig && free |=> contact)
		else $error("off-delay not following trigger");
	chk_offdly_retrig:
		assert property (cfg.mode == MODE_OFF_DELAY && $rose(trig) && free
			|=> elapsed == '0) else $error("retrigger kept time");
	chk_pulse_stretch:
		assert property (pulse_start ##1 !clr |-> contact)
		else $error("pulse too short");
	chk_flash_mark:
		assert property (cfg.mode == MODE_FLASH && $rose(trig) && free
			|=> contact) else $error("flash began with space");
endmodule // relay_port_checker
bind multi_mode_timing_relay relay_port_checker #(.TICK_CYC(TICK_CYC))
	i_relay_port_checker (.ref_clk(ref_clk), .rstn(rstn), .coils(coils),
	.cfg(cfg), .contact(contact), .elapsed(elapsed),
	.sp1_split(sp1_split), .sp2_split(sp2_split));
`default_nettype wire

// ---- sim/coil_circuit_model.sv ----
// Model of the circuit diagram that drives the relay coils
`timescale 1ns/1ps
`default_nettype none
module coil_circuit_model (
	input wire logic ref_clk,
	input wire timing_relay_pkg::coils_t req,
	output timing_relay_pkg::coils_t coils
);
	// Coils update once per scan, just after the edge, never mid-cycle
	initial coils = '0;
	always @(posedge ref_clk) begin
		coils <= #1 req;
	end
endmodule // coil_circuit_model
`default_nettype wire

// ---- sim/multi_mode_timing_relay_tb.sv ----
// Self-checking testbench for the timing relay
`timescale 1ns/1ps
`default_nettype none
module multi_mode_timing_relay_tb;
	import timing_relay_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	coils_t req = '0;
	coils_t coils;
	relay_cfg_t cfg = '0;
	logic contact;
	logic [T_W-1:0] elapsed;
	split_t sp1_split;
	split_t sp2_split;
	int errors = 0;
	int samples_checked = 0;
	int i;
	// Last entry is oversized and must clamp to 99:59
	logic [15:0] vals [4] = '{16'h0064, 16'h03ff, 16'h025e, 16'h1b58};
	logic [15:0] exps [4] = '{16'h0128, 16'h1103, 16'h0a06, 16'h633b};
	always #2 ref_clk = ~ref_clk;
	coil_circuit_model i_coil_circuit_model (.ref_clk(ref_clk), .req(req),
		.coils(coils));
	// Short tick keeps every delay within a few hundred cycles
	multi_mode_timing_relay #(.TICK_CYC(4)) i_multi_mode_timing_relay (
		.ref_clk(ref_clk), .rstn(rstn), .coils(coils), .cfg(cfg),
		.contact(contact), .elapsed(elapsed), .sp1_split(sp1_split),
		.sp2_split(sp2_split));
	// ==========================================
	// Tasks
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk_word(input logic [T_W-1:0] got, input logic [T_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({23'h0, got}, {23'h0, exp});
	endtask
	task automatic chk_split(input split_t got, input logic [15:0] exp);
		chk_word({8'h00, got}, {8'h00, exp});
	endtask
	task automatic coil(input logic [2:0] v);
		req = v;
		step(2);
	endtask
	task automatic set_cfg(input relay_mode_t m, input logic r,
		input logic [15:0] s1, input logic [15:0] s2);
		cfg = '{m, BASE_S, r, s1, s2};
		step(2);
	endtask
	task automatic wait_on(input logic v);
		int n;
		n = 0;
		while (contact !== v && n < 400) begin
			step(1);
			n++;
		end
		chk_bit(contact, v);
	endtask
	task automatic finish_test;
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		step(20000);
		errors++;
		finish_test;
	end
	// ==========================================
	// Tests
	initial begin
		step(8);
		rstn = 1'b1;
		for (i = 0; i < 4; i++) begin
			cfg = '{MODE_ON_DELAY, BASE_MS, 1'b0, vals[i], vals[i]};
			step(2);
			chk_split(sp1_split, exps[i]);
			chk_split(sp2_split, exps[i]);
			cfg.base = BASE_HM;
			step(2);
			chk_split(sp1_split, exps[i]);
			chk_split(sp2_split, exps[i]);
		end
		set_cfg(MODE_ON_DELAY, 1'b0, 16'h0005, 16'h0000);
		coil(3'b100);
		step(8);
		chk_bit(contact, 1'b0);
		coil(3'b000);
		chk_word(elapsed, '0);
		coil(3'b110);
		step(60);
		chk_bit(contact, 1'b0);
		coil(3'b100);
		wait_on(1'b1);
		coil(3'b110);
		chk_bit(contact, 1'b1);
		coil(3'b111);
		chk_bit(contact, 1'b0);
		chk_word(elapsed, '0);
		set_cfg(MODE_OFF_DELAY, 1'b0, 16'h0005, 16'h0000);
		coil(3'b100);
		chk_bit(contact, 1'b1);
		coil(3'b000);
		step(4);
		coil(3'b100);
		chk_word(elapsed, '0);
		coil(3'b000);
		wait_on(1'b0);
		coil(3'b100);
		coil(3'b001);
		chk_bit(contact, 1'b0);
		set_cfg(MODE_ON_OFF, 1'b0, 16'h0014, 16'h0005);
		coil(3'b100);
		coil(3'b000);
		for (i = 0; i < 100; i++) begin
			step(1);
			chk_bit(contact, 1'b0);
		end
		coil(3'b100);
		wait_on(1'b1);
		coil(3'b000);
		wait_on(1'b0);
		coil(3'b100);
		wait_on(1'b1);
		coil(3'b101);
		chk_bit(contact, 1'b0);
		set_cfg(MODE_PULSE, 1'b0, 16'h0005, 16'h0000);
		coil(3'b100);
		coil(3'b000);
		chk_bit(contact, 1'b1);
		wait_on(1'b0);
		coil(3'b100);
		coil(3'b101);
		chk_bit(contact, 1'b0);
		set_cfg(MODE_FLASH, 1'b0, 16'h0003, 16'h0003);
		coil(3'b100);
		chk_bit(contact, 1'b1);
		wait_on(1'b0);
		wait_on(1'b1);
		coil(3'b000);
		set_cfg(MODE_ON_DELAY, 1'b1, 16'h0005, 16'h0000);
		coil(3'b100);
		wait_on(1'b1);
		finish_test;
	end
endmodule // multi_mode_timing_relay_tb
`default_nettype wire
